// [dv/codec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module codec_model (
   input wire logic clock,
   input wire logic rst,
   input wire second_audio_pkg::pin_drive_t pinDrive,
   input wire logic codecOn,
   input wire logic [9:0] extOe,
   input wire logic [9:0] extLevel,
   input wire logic [23:0] rxWord,
   output logic [9:0] pinLevel
);
   import second_audio_pkg::*;
   logic [23:0] shift;
   logic bitOut;
   logic lastClk;
   logic [9:0] idle;
   // released lines flip every cycle so a stale level never passes for data
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         idle <= 10'h155;
      else
         idle <= ~idle;
   end
   // codec sends its word MSB first, changing on the falling shared bit clock
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lastClk <= 1'b0;
         shift <= 24'h00_0000;
         bitOut <= 1'b0;
      end
      else
      begin
         lastClk <= pinLevel[PIN_TXCLK];
         if (lastClk && !pinLevel[PIN_TXCLK])
         begin
            if (pinLevel[PIN_TXFS])
            begin
               bitOut <= rxWord[23];
               shift <= {rxWord[22:0], 1'b0};
            end
            else
            begin
               bitOut <= shift[23];
               shift <= {shift[22:0], 1'b0};
            end
         end
      end
   end
   // the codec drives only lines that the device leaves as inputs
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (pinDrive.oe[i])
            pinLevel[i] = pinDrive.out[i];
         else if (codecOn && i == 5)
            pinLevel[i] = bitOut;
         else if (extOe[i])
            pinLevel[i] = extLevel[i];
         else
            pinLevel[i] = idle[i];
      end
   end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import second_audio_pkg::*;
   logic clock;
   logic rst;
   logic [3:0] addr;
   logic [23:0] wrData;
   logic wrStrobe;
   logic rdStrobe;
   logic [23:0] rdData;
   logic [9:0] pinIn;
   pin_drive_t pinDrive;
   first_port_t firstPort;
   logic [3:0] firstPortIn;
   logic txReady;
   logic codecOn;
   logic [9:0] extOe;
   logic [9:0] extLevel;
   logic [23:0] rxWord;
   logic [23:0] rdQ[$];
   logic [23:0] serQ[$];
   logic rdLate;
   logic lastClk;
   logic lastOe;
   logic [23:0] serShift;
   logic [23:0] word;
   logic [9:0] exp10;
   int bitCnt;
   int failCount;
   int compares;
   int seed;
   int half;

   second_audio_port second_audio_port_inst (.clock(clock), .rst(rst), .addr(addr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
      .pinIn(pinIn), .pinDrive(pinDrive), .firstPort(firstPort),
      .firstPortIn(firstPortIn), .txReady(txReady));
   codec_model codec_model_inst (.clock(clock), .rst(rst), .pinDrive(pinDrive),
      .codecOn(codecOn), .extOe(extOe), .extLevel(extLevel), .rxWord(rxWord),
      .pinLevel(pinIn));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
         failCount++;
      end
   endtask

   task automatic closeOut;
      $display("compares %0d mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic regWrite(input logic [3:0] a, input logic [23:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clock);
      wrStrobe <= 1'b0;
   endtask

   // the expected word is queued; the read monitor compares it a cycle later
   task automatic regRead(input logic [3:0] a, input logic [23:0] exp);
      @(posedge clock);
      addr <= a;
      rdStrobe <= 1'b1;
      rdQ.push_back(exp);
      @(posedge clock);
      rdStrobe <= 1'b0;
   endtask

   task automatic measureHalf(output int n);
      logic v;
      int k;
      @(posedge clock);
      v = pinIn[PIN_TXCLK];
      for (k = 0; k < 200 && pinIn[PIN_TXCLK] === v; k++) @(posedge clock);
      v = pinIn[PIN_TXCLK];
      for (n = 0; n < 200 && pinIn[PIN_TXCLK] === v; n++) @(posedge clock);
   endtask

   always @(posedge clock) rdLate <= rdStrobe;

   always @(negedge clock)
   begin
      if (rdLate === 1'b1 && rdQ.size() > 0)
         check("rdData", rdData, rdQ.pop_front());
   end

   // serial monitor: word starts at the rising bit clock that sees frame sync
   always @(posedge clock)
   begin
      lastClk <= pinDrive.out[PIN_TXCLK];
      lastOe <= pinDrive.oe[0];
      // pin 0 is also driven by the sharing and gpio tests; only the serial test counts
      if (codecOn === 1'b1 && lastOe === 1'b0 && pinDrive.oe[0] === 1'b1)
         check("syncAtDrive", {23'h0, pinDrive.out[PIN_TXFS]}, 24'h1);
      if (codecOn === 1'b1 && lastClk === 1'b0 && pinDrive.out[PIN_TXCLK] === 1'b1 &&
          pinDrive.oe[0] === 1'b1)
      begin
         serShift = {serShift[22:0], pinDrive.out[0]};
         if (pinDrive.out[PIN_TXFS] === 1'b1)
            bitCnt = 1;
         else if (bitCnt > 0)
            bitCnt++;
         if (bitCnt == 24 && serQ.size() > 0)
            check("serialWord", serShift, serQ.pop_front());
      end
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      $display("timeout");
      failCount++;
      closeOut();
   end

   initial
   begin
      seed = 32'hd339_ae30;
      rst = 1'b1;
      addr = 4'h0;
      wrData = 24'h00_0000;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      firstPort = '0;
      codecOn = 1'b0;
      extOe = 10'h000;
      extLevel = 10'h000;
      bitCnt = 0;
      failCount = 0;
      compares = 0;
      serShift = 24'h00_0000;
      rxWord = 24'($random(seed));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      regRead(REG_PIN_SELECT, 24'h00_0000);
      regRead(REG_TX_CLOCK_CONTROL, 24'h00_0000);
      regRead(REG_TX_CONTROL, 24'h00_0000);
      regRead(4'hc, 24'h00_0000);
      $display("test reset done");
      for (int k = 0; k < 4; k++)
      begin
         word = 24'($random(seed));
         regWrite(REG_PIN_SELECT, word);
         regRead(REG_PIN_SELECT, {20'h0, word[3:0]});
         word = word & 24'he3_feff;
         regWrite(REG_TX_CLOCK_CONTROL, word);
         regRead(REG_TX_CLOCK_CONTROL, word);
         word = 24'($random(seed)) & 24'hff_ffc0;
         regWrite(REG_TX_CONTROL, word);
         regRead(REG_TX_CONTROL, word);
      end
      regWrite(REG_SOFT_RESET, 24'h00_0001);
      regRead(REG_PIN_SELECT, 24'h00_0000);
      regRead(REG_TX_CLOCK_CONTROL, 24'h00_0000);
      regRead(REG_TX_CONTROL, 24'h00_0000);
      $display("test registers done");
      firstPort <= '{out: 4'($random(seed)), oe: 4'h0, uses: 4'hf};
      extOe <= 10'h3ff;
      extLevel <= 10'($random(seed));
      cycles(5);
      check("firstPortIn", {20'h0, firstPortIn}, {20'h0, extLevel[3:0]});
      firstPort.oe <= 4'hf;
      cycles(3);
      check("sharedOe", {20'h0, pinDrive.oe[3:0]}, 24'h00_000f);
      check("sharedOut", {20'h0, pinDrive.out[3:0]}, {20'h0, firstPort.out});
      regWrite(REG_PIN_SELECT, 24'h00_000f);
      cycles(5);
      check("firstPortIn", {20'h0, firstPortIn}, 24'h00_0000);
      check("sharedOe", {20'h0, pinDrive.oe[3:0]}, 24'h00_0000);
      $display("test sharing done");
      regWrite(REG_PIN_SELECT, 24'h00_0000);
      firstPort <= '0;
      word = 24'($random(seed));
      regWrite(REG_GPIO_DIR, 24'h00_0fff);
      regWrite(REG_GPIO_DATA, word);
      cycles(3);
      for (int i = 0; i < NUM_PINS; i++) exp10[i] = word[PE_BIT[i]];
      check("gpioOut", {14'h0, pinDrive.out}, {14'h0, exp10});
      check("gpioOe", {14'h0, pinDrive.oe}, 24'h00_03ff);
      regWrite(REG_GPIO_DIR, 24'h00_0000);
      extLevel <= 10'($random(seed));
      cycles(5);
      word = 24'h00_0000;
      for (int i = 0; i < NUM_PINS; i++) word[PE_BIT[i]] = extLevel[i];
      regRead(REG_GPIO_DATA, word);
      $display("test gpio done");
      regWrite(REG_PIN_FUNCTION, 24'h00_0018);
      for (int k = 0; k < 4; k++)
      begin
         regWrite(REG_TX_CLOCK_CONTROL, {1'b1, 2'(k), 21'h0});
         cycles(3);
         check("clockSyncOe", {22'h0, pinDrive.oe[PIN_TXFS], pinDrive.oe[PIN_TXCLK]},
            24'(k));
      end
      regWrite(REG_TX_CLOCK_CONTROL, 24'h20_0000);
      cycles(3);
      check("clockOe", {23'h0, pinDrive.oe[PIN_TXCLK]}, 24'h00_0000);
      regWrite(REG_TX_CLOCK_CONTROL, 24'he0_0007);
      measureHalf(half);
      check("halfPeriod", 24'(half), 24'h00_0008);
      regWrite(REG_TX_CLOCK_CONTROL, 24'he0_4007);
      measureHalf(half);
      check("halfPeriod", 24'(half), 24'h00_0010);
      $display("test clocks done");
      regWrite(REG_SOFT_RESET, 24'h00_0001);
      for (int k = 0; k < 3; k++)
      begin
         word = 24'($random(seed));
         regWrite(REG_TX_DATA, word);
         if (k < 2)
            serQ.push_back(word);
      end
      cycles(1);
      check("txReady", {23'h0, txReady}, 24'h00_0000);
      regRead(REG_STATUS, 24'h00_0008);
      regWrite(REG_PIN_SELECT, 24'h00_0001);
      regWrite(REG_PIN_FUNCTION, 24'h00_0858);
      codecOn <= 1'b1;
      extOe <= 10'h000;
      // all three direction bits set, polarity bit left clear
      regWrite(REG_TX_CLOCK_CONTROL, 24'he0_0007);
      regWrite(REG_TX_CONTROL, 24'h00_0101);
      cycles(1);
      check("dataOeWait", {23'h0, pinDrive.oe[0]}, 24'h00_0000);
      for (int k = 0; k < 4000 && serQ.size() > 0; k++) @(posedge clock);
      check("wordsLeft", 24'(serQ.size()), 24'h00_0000);
      cycles(800);
      regRead(REG_RX_DATA, rxWord);
      regRead(REG_STATUS, 24'h00_0003);
      cycles(2);
      $display("test serial done");
      closeOut();
   end
endmodule
`default_nettype wire

// [verilog/second_audio_pkg.sv]
package second_audio_pkg;
   localparam int NUM_PINS = 10;
   localparam logic [3:0] REG_PIN_SELECT = 4'h0;
   localparam logic [3:0] REG_TX_CLOCK_CONTROL = 4'h1;
   localparam logic [3:0] REG_TX_CONTROL = 4'h2;
   localparam logic [3:0] REG_TX_DATA = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_PIN_FUNCTION = 4'h5;
   localparam logic [3:0] REG_GPIO_DIR = 4'h6;
   localparam logic [3:0] REG_GPIO_DATA = 4'h7;
   localparam logic [3:0] REG_RX_DATA = 4'h8;
   localparam logic [3:0] REG_SOFT_RESET = 4'h9;
   localparam logic [23:0] RESET_WORD = 24'h00_0000;
   localparam logic [11:0] RESET_GPIO = 12'h000;
   localparam logic [3:0] RESET_SELECT = 4'h0;
   localparam int TCC_DIV_LSB = 0;
   localparam int TCC_WPF_LSB = 9;
   localparam int TCC_EXTRA_LSB = 14;
   localparam int TCC_HF_POL = 20;
   localparam int TCC_CLK_DIR = 21;
   localparam int TCC_FS_DIR = 22;
   localparam int TCC_HF_DIR = 23;
   localparam int TC_SYNC = 8;
   localparam int ST_UNDERRUN = 0;
   localparam logic [4:0] WORD_LAST = 5'h17;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam int PIN_RXCLK = 6;
   localparam int PIN_TXCLK = 7;
   localparam int PIN_RXFS = 8;
   localparam int PIN_TXFS = 9;
   // port-E bit taken by each pin when its serial function is off
   localparam int PE_BIT [NUM_PINS] = '{11, 10, 9, 8, 7, 6, 0, 3, 1, 4};
   typedef struct packed
   {
      logic [9:0] out;
      logic [9:0] oe;
   } pin_drive_t;
   typedef struct packed
   {
      logic [3:0] out;
      logic [3:0] oe;
      logic [3:0] uses;
   } first_port_t;
   typedef enum logic [1:0]
   {
      TX_OFF = 2'b00,
      TX_WAIT = 2'b01,
      TX_RUN = 2'b10
   } tx_state_t;
endpackage

// [verilog/second_audio_port.sv]
// Operation
// - mux bit selects first or second port
// - resets clear the pin-multiplex register
// - idle shared pins become port-E bits 11..8
// - idle dedicated pins become their port-E bits
// - data pin direction follows its transmit enable
// - clock and sync pins follow configured direction
// - sync mode clocks receiver with transmit clock
// - extra divider field only divides bit clock
// - direction bits pick clock source and drivers
// - clock control sets rates, sources, frame size
// - resets clear the transmit clock-control register
// - resets clear the transmit control register
// - six own pins, four shared, no HF pins
// - enabled transmitter floats until next frame sync
`timescale 1ns/1ps
`default_nettype none
module second_audio_port (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [23:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output var logic [23:0] rdData,
   input wire logic [9:0] pinIn,
   output var second_audio_pkg::pin_drive_t pinDrive,
   input wire second_audio_pkg::first_port_t firstPort,
   output logic [3:0] firstPortIn,
   output logic txReady
);
   import second_audio_pkg::*;

   function automatic logic wrHit(input logic s, input logic [3:0] a, input logic [3:0] off);
      return s && (a == off);
   endfunction

   logic [3:0] pinSelect;
   logic [23:0] txClockCtrl;
   logic [23:0] txCtrl;
   logic [11:0] pinFunction;
   logic [11:0] gpioDir;
   logic [11:0] gpioData;
   logic softReset;
   logic [9:0] pinMeta;
   logic [9:0] pinSync;
   logic [9:0] pinPrev;
   logic [7:0] divCnt;
   logic [3:0] extraCnt;
   logic intClkLevel;
   logic [4:0] bitCnt;
   logic [4:0] slotCnt;
   logic fsDrive;
   tx_state_t txState;
   logic [23:0] txShift;
   logic [23:0] fifoMem [2];
   logic wrPtr;
   logic rdPtr;
   logic [1:0] fifoCount;
   logic underrun;
   logic [23:0] rxShift;
   logic [23:0] rxWord;
   logic [9:0] fnPin;
   logic [9:0] serOut;
   logic [9:0] serOe;
   logic [11:0] peIn;
   pin_drive_t next_pinDrive;

   assign softReset = wrHit(wrStrobe, addr, REG_SOFT_RESET) && wrData[0];

   // a software reset clears these exactly as the hardware reset does
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pinSelect <= RESET_SELECT;
         txClockCtrl <= RESET_WORD;
         txCtrl <= RESET_WORD;
      end
      else if (softReset)
      begin
         pinSelect <= RESET_SELECT;
         txClockCtrl <= RESET_WORD;
         txCtrl <= RESET_WORD;
      end
      else
      begin
         if (wrHit(wrStrobe, addr, REG_PIN_SELECT))
            pinSelect <= wrData[3:0];
         if (wrHit(wrStrobe, addr, REG_TX_CLOCK_CONTROL))
            txClockCtrl <= wrData;
         if (wrHit(wrStrobe, addr, REG_TX_CONTROL))
            txCtrl <= wrData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pinFunction <= RESET_GPIO;
         gpioDir <= RESET_GPIO;
         gpioData <= RESET_GPIO;
      end
      else if (softReset)
      begin
         pinFunction <= RESET_GPIO;
         gpioDir <= RESET_GPIO;
         gpioData <= RESET_GPIO;
      end
      else
      begin
         if (wrHit(wrStrobe, addr, REG_PIN_FUNCTION))
            pinFunction <= wrData[11:0];
         if (wrHit(wrStrobe, addr, REG_GPIO_DIR))
            gpioDir <= wrData[11:0];
         if (wrHit(wrStrobe, addr, REG_GPIO_DATA))
            gpioData <= wrData[11:0];
      end
   end

   // pins are asynchronous to the core clock; edges are taken after two stages
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pinMeta <= 10'h000;
         pinSync <= 10'h000;
         pinPrev <= 10'h000;
      end
      else
      begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   logic modeValid;
   logic intClk;
   logic fsOut;
   logic syncMode;
   logic [5:0] teBits;
   logic [7:0] bitDiv;
   logic [3:0] extraDiv;
   logic [4:0] wordsLast;
   logic divRun;
   logic halfTick;
   logic shiftEv;
   logic sampleEv;
   logic frameEnd;
   logic fsHit;
   logic slotLoad;
   logic frameStart;
   logic going;
   logic push;
   logic pop;
   logic rxOn;

   // with the high-frequency direction bit clear every setting is reserved,
   // so the transmitter is held still rather than guessing
   assign modeValid = txClockCtrl[TCC_HF_DIR];
   assign intClk = txClockCtrl[TCC_CLK_DIR];
   assign fsOut = txClockCtrl[TCC_FS_DIR];
   assign syncMode = txCtrl[TC_SYNC];
   assign teBits = txCtrl[5:0];
   assign bitDiv = txClockCtrl[TCC_DIV_LSB +: 8];
   assign extraDiv = txClockCtrl[TCC_EXTRA_LSB +: 4];
   assign wordsLast = txClockCtrl[TCC_WPF_LSB +: 5];
   assign divRun = modeValid && intClk;
   assign halfTick = divRun && (divCnt == bitDiv) && (extraCnt == extraDiv);

   // the extra stage has no pin of its own; it only stretches the bit clock
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         divCnt <= 8'h00;
         extraCnt <= 4'h0;
         intClkLevel <= 1'b0;
      end
      else if (!divRun)
      begin
         divCnt <= 8'h00;
         extraCnt <= 4'h0;
         intClkLevel <= 1'b0;
      end
      else if (divCnt == bitDiv)
      begin
         divCnt <= 8'h00;
         if (extraCnt == extraDiv)
         begin
            extraCnt <= 4'h0;
            intClkLevel <= ~intClkLevel;
         end
         else
            extraCnt <= extraCnt + 4'h1;
      end
      else
         divCnt <= divCnt + 8'h01;
   end

   // data changes on the falling bit-clock edge, is sampled on the rising one
   assign shiftEv = modeValid && (intClk ? (halfTick && intClkLevel) :
                    (pinPrev[PIN_TXCLK] && !pinSync[PIN_TXCLK]));
   assign sampleEv = modeValid && (intClk ? (halfTick && !intClkLevel) :
                     (!pinPrev[PIN_TXCLK] && pinSync[PIN_TXCLK]));
   assign frameEnd = (bitCnt == WORD_LAST) && (slotCnt == wordsLast);
   assign fsHit = fsOut ? frameEnd : pinSync[PIN_TXFS];
   assign slotLoad = shiftEv && (fsHit || (bitCnt == WORD_LAST));
   assign frameStart = shiftEv && fsHit;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bitCnt <= 5'h00;
         slotCnt <= 5'h00;
         fsDrive <= 1'b0;
      end
      else if (!modeValid)
      begin
         // a frozen transmitter restarts its frame count from zero, so no
         // half-counted frame from an earlier setting delays the next start
         bitCnt <= 5'h00;
         slotCnt <= 5'h00;
         fsDrive <= 1'b0;
      end
      else if (shiftEv)
      begin
         fsDrive <= fsOut && fsHit;
         if (fsHit)
         begin
            bitCnt <= 5'h00;
            slotCnt <= 5'h00;
         end
         else if (bitCnt == WORD_LAST)
         begin
            bitCnt <= 5'h00;
            slotCnt <= slotCnt + 5'h01;
         end
         else
            bitCnt <= bitCnt + 5'h01;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         txState <= TX_OFF;
      else if (!modeValid || teBits == 6'h00)
         txState <= TX_OFF;
      else
      begin
         case (txState)
            TX_OFF: txState <= TX_WAIT;
            TX_WAIT: if (frameStart) txState <= TX_RUN;
            TX_RUN: txState <= TX_RUN;
            default: txState <= TX_OFF;
         endcase
      end
   end

   assign going = (txState == TX_RUN) || ((txState == TX_WAIT) && frameStart);
   assign push = wrHit(wrStrobe, addr, REG_TX_DATA) && (fifoCount != FIFO_DEPTH);
   assign pop = slotLoad && going && (fifoCount != 2'h0);
   assign txReady = fifoCount != FIFO_DEPTH;

   // two words of slack so software can refill while a slot shifts out
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
         fifoCount <= 2'h0;
         fifoMem[0] <= RESET_WORD;
         fifoMem[1] <= RESET_WORD;
      end
      else
      begin
         if (push)
         begin
            fifoMem[wrPtr] <= wrData;
            wrPtr <= ~wrPtr;
         end
         if (pop)
            rdPtr <= ~rdPtr;
         case ({push, pop})
            2'b10: fifoCount <= fifoCount + 2'h1;
            2'b01: fifoCount <= fifoCount - 2'h1;
            default: fifoCount <= fifoCount;
         endcase
      end
   end

   // an empty buffer at slot start sends zeros and marks an underrun
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         txShift <= RESET_WORD;
      else if (slotLoad)
         txShift <= pop ? fifoMem[rdPtr] : RESET_WORD;
      else if (shiftEv)
         txShift <= {txShift[22:0], 1'b0};
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         underrun <= 1'b0;
      else if (slotLoad && going && fifoCount == 2'h0)
         underrun <= 1'b1;
      else if (wrHit(wrStrobe, addr, REG_STATUS) && wrData[ST_UNDERRUN])
         underrun <= 1'b0;
   end

   // receiver path is only the synchronous case on the last data pin
   assign rxOn = syncMode && modeValid && fnPin[5] && !teBits[5];

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rxShift <= RESET_WORD;
      else if (sampleEv && rxOn)
         rxShift <= {rxShift[22:0], pinSync[5]};
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rxWord <= RESET_WORD;
      else if (slotLoad && rxOn)
         rxWord <= rxShift;
   end

   always_comb
   begin
      fnPin = 10'h000;
      peIn = 12'h000;
      for (int i = 0; i < NUM_PINS; i++)
      begin
         fnPin[i] = pinFunction[PE_BIT[i]];
         peIn[PE_BIT[i]] = pinSync[i];
      end
   end

   always_comb
   begin
      serOut = 10'h000;
      serOe = 10'h000;
      for (int i = 0; i < 6; i++)
      begin
         serOut[i] = txShift[23];
         serOe[i] = (txState == TX_RUN) && teBits[i];
      end
      serOut[PIN_TXCLK] = intClkLevel;
      serOe[PIN_TXCLK] = divRun;
      serOut[PIN_TXFS] = fsDrive;
      serOe[PIN_TXFS] = modeValid && fsOut;
   end

   // with their serial function on, receive clock and sync pins stay inputs: the far end drives them
   always_comb
   begin
      next_pinDrive = '0;
      for (int i = 0; i < NUM_PINS; i++)
      begin
         next_pinDrive.out[i] = fnPin[i] ? serOut[i] : gpioData[PE_BIT[i]];
         next_pinDrive.oe[i] = fnPin[i] ? serOe[i] : gpioDir[PE_BIT[i]];
      end
      // only the four shared pins can be handed to the first port
      for (int i = 0; i < 4; i++)
      begin
         if (!pinSelect[i])
         begin
            if (firstPort.uses[i])
            begin
               next_pinDrive.out[i] = firstPort.out[i];
               next_pinDrive.oe[i] = firstPort.oe[i];
            end
            else
            begin
               next_pinDrive.out[i] = gpioData[PE_BIT[i]];
               next_pinDrive.oe[i] = gpioDir[PE_BIT[i]];
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pinDrive <= '0;
      else
         pinDrive <= next_pinDrive;
   end

   assign firstPortIn = pinSync[3:0] & ~pinSelect;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdData <= RESET_WORD;
      else if (!rdStrobe)
         rdData <= RESET_WORD;
      else
      begin
         case (addr)
            REG_PIN_SELECT: rdData <= {20'h0_0000, pinSelect};
            REG_TX_CLOCK_CONTROL: rdData <= txClockCtrl;
            REG_TX_CONTROL: rdData <= txCtrl;
            REG_STATUS: rdData <= {20'h0_0000, fifoCount, txState == TX_RUN, underrun};
            REG_PIN_FUNCTION: rdData <= {12'h000, pinFunction};
            REG_GPIO_DIR: rdData <= {12'h000, gpioDir};
            REG_GPIO_DATA: rdData <= {12'h000, (gpioDir & gpioData) | (~gpioDir & peIn)};
            REG_RX_DATA: rdData <= rxWord;
            default: rdData <= RESET_WORD;
         endcase
      end
   end

   // helper: cycles between internal half-period ticks under steady settings
   logic [13:0] gapCnt;
   logic gapSeen;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         gapCnt <= 14'h0000;
         gapSeen <= 1'b0;
      end
      else if (wrHit(wrStrobe, addr, REG_TX_CLOCK_CONTROL) || softReset || !divRun)
      begin
         gapCnt <= 14'h0000;
         gapSeen <= 1'b0;
      end
      else if (halfTick)
      begin
         gapCnt <= 14'h0000;
         gapSeen <= 1'b1;
      end
      else
         gapCnt <= gapCnt + 14'h0001;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_MUX_DISCONNECT:
      assert property ((firstPortIn & pinSelect) == 4'h0)
         else $error("disconnected first port sees a nonzero input");
   AST_SOFT_RESET:
      assert property (softReset |=> pinSelect == 4'h0 && txClockCtrl == 24'h00_0000 &&
                       txCtrl == 24'h00_0000)
         else $error("software reset left a control register set");
   AST_FIRST_OWNS:
      assert property (!pinSelect[0] && firstPort.uses[0] |=>
                       pinDrive.oe[0] == $past(firstPort.oe[0]))
         else $error("shared pin not routed to first port");
   AST_SHARED_GPIO:
      assert property (!pinSelect[0] && !firstPort.uses[0] && gpioDir[11] |=>
                       pinDrive.oe[0] && pinDrive.out[0] == $past(gpioData[11]))
         else $error("idle shared pin 0 not on port-E bit 11");
   AST_DEDICATED_GPIO:
      assert property (!pinFunction[7] && gpioDir[7] |=>
                       pinDrive.oe[4] && pinDrive.out[4] == $past(gpioData[7]))
         else $error("idle data pin 4 not on port-E bit 7");
   AST_FLOAT_UNTIL_FS:
      assert property (txState == TX_WAIT && !frameStart && pinFunction[7] |=> !pinDrive.oe[4])
         else $error("transmitter drove before frame sync");
   AST_RESERVED_STILL:
      assert property (!modeValid |-> !shiftEv && !sampleEv ##1 !pinDrive.oe[PIN_TXFS] ||
                       !pinFunction[4])
         else $error("transmitter moved with reserved clock setting");
   AST_CLOCK_DRIVEN:
      assert property (modeValid && intClk && pinFunction[3] |=>
                       pinDrive.oe[PIN_TXCLK] && pinDrive.out[PIN_TXCLK] == $past(intClkLevel))
         else $error("internal bit clock not driven on its pin");
   AST_DIV_PERIOD:
      assert property (halfTick && gapSeen |->
                       gapCnt == 14'(({6'h00, bitDiv} + 14'h0001) *
                                     ({10'h000, extraDiv} + 14'h0001) - 14'h0001))
         else $error("bit clock period ignores the divider stages");
   AST_SYNC_RX:
      assert property (sampleEv && rxOn |=> rxShift[0] == $past(pinSync[5]))
         else $error("receiver not clocked by transmit bit clock");

   COV_FRAME_RUN: cover property (txState == TX_WAIT ##1 txState == TX_RUN);
   COV_UNDERRUN: cover property (!underrun ##1 underrun);
   COV_FIFO_FULL: cover property (fifoCount == FIFO_DEPTH ##[1:200] pop);
endmodule
`default_nettype wire
